// ==== src/pdi_pkg.sv ====
// Shared constants and types for the I/O process and diagnostic interrupt unit
package pdi_pkg;

   // ==========================================================
   // Sizes
   localparam int PDI_CH = 4;
   localparam int PDI_CHW = 2;
   localparam int PDI_ALARM_PINS = 16;
   localparam int PDI_ALARM_BYTES = 2;
   localparam int PDI_FAULTS = 5;
   localparam int PDI_SRCS = PDI_CH + PDI_FAULTS;
   localparam int PDI_BYTE_W = 8;
   localparam int PDI_WORD_W = 32;
   localparam int PDI_GATED_CNT = 3;

   // ==========================================================
   // Handler-side local data offsets (base word, detail double word)
   localparam int PDI_LOC_BASE_OFS = 6;
   localparam int PDI_LOC_DETAIL_OFS = 8;

   // ==========================================================
   // Register map
   localparam logic [7:0] PDI_CTRL_ADDR = 8'h00;
   localparam logic [7:0] PDI_BASE_ADDR = 8'h04;
   localparam logic [7:0] PDI_STAT_ADDR = 8'h08;
   localparam logic [7:0] PDI_DIAG_REC_ADDR = 8'h7F;
   localparam int PDI_CTRL_MODE_LSB = 0;
   localparam int PDI_CTRL_IRQSEL_BIT = 2;
   localparam int PDI_CTRL_SWGATE_BIT = 3;
   localparam int PDI_DIAG_EN_BIT = 0;
   localparam int PDI_STAT_ACTIVE_LSB = 0;
   localparam int PDI_STAT_LOST_LSB = 12;
   localparam int PDI_STAT_DISP_LSB = 16;
   localparam int PDI_STAT_SUSP_BIT = 18;
   localparam int PDI_STAT_SFI_BIT = 19;
   localparam int PDI_STAT_PQ_LSB = 20;
   localparam int PDI_STAT_DQ_LSB = 24;

   // ==========================================================
   // Event byte fields
   localparam int PDI_BIT_GATE_OPEN = 0;
   localparam int PDI_BIT_GATE_CLOSE = 1;
   localparam int PDI_BIT_WRAP = 2;
   localparam int PDI_BIT_CMP = 3;
   localparam int PDI_BIT_LATCH = 4;
   localparam int PDI_BIT_FREQ_END = 0;

   // ==========================================================
   // Diagnostic record fields and fault inputs
   localparam int PDI_REC_MODULE_FAIL = 0;
   localparam int PDI_REC_INT_ERR = 1;
   localparam int PDI_REC_EXT_ERR = 2;
   localparam int PDI_REC_EXT_SUPPLY = 4;
   localparam int PDI_REC_CHAN_INFO = 12;
   localparam int PDI_REC_INT_SUPPLY = 20;
   localparam int PDI_REC_LOST = 30;
   localparam int PDI_FLT_OUT_SUPPLY = 0;
   localparam int PDI_FLT_BUS_SUPPLY = 1;
   localparam int PDI_FLT_IN_SUPPLY = 2;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PDI_MODE_ALARM = 2'h0,
      PDI_MODE_COUNT = 2'h1,
      PDI_MODE_FREQ = 2'h2
   } pdi_mode_t;

   typedef struct packed {
      logic [PDI_CH-1:0] wrap;
      logic [PDI_CH-1:0] cmp;
      logic gate_open;
      logic gate_close;
      logic latch;
   } pdi_cnt_ev_t;

   typedef struct packed {
      logic [15:0] base_addr;
      logic [PDI_WORD_W-1:0] detail;
   } pdi_proc_info_t;

   typedef struct packed {
      logic outgoing;
      logic [3:0] source;
      logic [PDI_WORD_W-1:0] record;
   } pdi_diag_info_t;

   typedef struct packed {
      logic outgoing;
      logic [3:0] source;
   } pdi_dq_entry_t;

endpackage : pdi_pkg

// ==== src/pdi_irq_unit.sv ====
// Process and diagnostic interrupt unit of the integrated I/O part
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// How it works
// RL1: Input edges, compare match and counter wrap raise process interrupts.
// RL2: Hardware gate open/close with software gate open raises a process interrupt.
// RL3: Lost interrupts, supply failures and shorts raise diagnostic interrupts.
// RL4: Channel interrupts only when interrupt selection enables diagnostics plus process.
// RL5: Process interrupt carries 16-bit base address and 32-bit event word.
// RL6: Alarm mode: bytes 8 and 9 flag input edges, bytes 10, 11 zero.
// RL7: Counters 0 to 2: bit 2 wrap, bit 3 compare, rest zero.
// RL8: Counter 3 byte: gate open, closed, wrap, compare, latch in bits 0-4.
// RL9: Frequency mode: bit 0 of each byte marks end of integration.
// RL10: Module diagnostic enable sits in configuration record 7Fh.
// RL11: Same-channel event during its process service raises a diagnostic.
// RL12: Incoming diagnostic preempts running process service.
// RL13: Events arriving during diagnostic handling are held.
// RL14: Held diagnostics go first in arrival order, then held process events.
// RL15: Process events of a channel in diagnostic state are discarded.
// RL16: When the causing process service completes, an outgoing diagnostic follows.
// RL17: Channel events between incoming and outgoing diagnostic are dropped.
// RL18: Fault indicator lit from first incoming to last outgoing handled.
// RL19: Every incoming and outgoing diagnostic pulses one log entry.
// RL20: Lost interrupt record sets bit 6 of byte 3.
// RL21: Queues hold one process and two diagnostics per source, in FIFO order.
// RL22: Handler acknowledges each service with a pulse to release the next.
module pdi_irq_unit #(
   parameter int DIAG_DEPTH = 32
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] bus_addr_in,
   input wire logic [31:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   output logic [31:0] bus_rdata_out,
   input wire logic [pdi_pkg::PDI_ALARM_PINS-1:0] alarm_pins_in,
   input wire pdi_pkg::pdi_cnt_ev_t cnt_events_in,
   input wire logic [pdi_pkg::PDI_CH-1:0] freq_end_in,
   input wire logic [pdi_pkg::PDI_FAULTS-1:0] fault_pins_in,
   input wire logic proc_ack_in,
   input wire logic diag_ack_in,
   output logic proc_irq_out,
   output pdi_pkg::pdi_proc_info_t proc_info_out,
   output logic diag_irq_out,
   output pdi_pkg::pdi_diag_info_t diag_info_out,
   output logic diag_log_out,
   output logic system_fault_indicator_out
);
   import pdi_pkg::*;

   // ==========================================================
   // State
   localparam int DQW = $clog2(DIAG_DEPTH);

   typedef enum logic [1:0] {
      D_IDLE,
      D_PROC,
      D_DIAG
   } pdi_disp_t;

   typedef struct packed {
      logic [PDI_ALARM_PINS-1:0] pin_s1;
      logic [PDI_ALARM_PINS-1:0] pin_s2;
      logic [PDI_ALARM_PINS-1:0] pin_prev;
      logic [PDI_FAULTS-1:0] flt_s1;
      logic [PDI_FAULTS-1:0] flt_s2;
      logic [PDI_FAULTS-1:0] flt_prev;
      pdi_mode_t mode;
      logic irq_sel;
      logic software_count_gate;
      logic diag_en;
      logic [15:0] base;
      logic [PDI_CH-1:0][PDI_BYTE_W-1:0] pend;
      logic [PDI_CH-1:0] queued;
      logic [PDI_CH-1:0] lost;
      logic [PDI_SRCS-1:0] active;
      logic [PDI_CH-1:0][PDI_CHW-1:0] pq;
      logic [PDI_CHW:0] pq_rd;
      logic [PDI_CHW:0] pq_wr;
      pdi_dq_entry_t [DIAG_DEPTH-1:0] dq;
      logic [DQW:0] dq_rd;
      logic [DQW:0] dq_wr;
      pdi_disp_t disp;
      logic susp;
      logic [PDI_CHW-1:0] svc_ch;
      pdi_proc_info_t proc_info;
      pdi_diag_info_t diag_info;
      logic log;
      logic sfi;
      logic [31:0] rdata;
   } pdi_state_t;

   pdi_state_t r_reg;
   pdi_state_t r_next;

   // ==========================================================
   // Functions
   function automatic logic [PDI_BYTE_W-1:0] chan_bits(pdi_mode_t m, int c,
         logic [PDI_ALARM_PINS-1:0] e, pdi_cnt_ev_t k, logic [PDI_CH-1:0] f, logic swg);
      logic [PDI_BYTE_W-1:0] b;
      b = '0;
      unique case (m)
         PDI_MODE_ALARM: begin
            if (c < PDI_ALARM_BYTES) begin
               b = e[c*PDI_BYTE_W +: PDI_BYTE_W]; // [RL1] [RL6]
            end
         end
         PDI_MODE_COUNT: begin
            b[PDI_BIT_WRAP] = k.wrap[c]; // [RL1] [RL7]
            b[PDI_BIT_CMP] = k.cmp[c]; // [RL7]
            if (c == PDI_GATED_CNT) begin
               b[PDI_BIT_GATE_OPEN] = k.gate_open & swg; // [RL2] [RL8]
               b[PDI_BIT_GATE_CLOSE] = k.gate_close & swg; // [RL2] [RL8]
               b[PDI_BIT_LATCH] = k.latch; // [RL8]
            end
         end
         PDI_MODE_FREQ: b[PDI_BIT_FREQ_END] = f[c]; // [RL9]
         default: b = '0;
      endcase
      return b;
   endfunction : chan_bits

   // Byte for offset 8 lands in the top lane, as the handler reads words big-endian
   function automatic logic [PDI_WORD_W-1:0] place(logic [PDI_CHW-1:0] c,
         logic [PDI_BYTE_W-1:0] b);
      logic [PDI_WORD_W-1:0] d;
      d = '0;
      d[PDI_WORD_W - PDI_BYTE_W - int'(c)*PDI_BYTE_W +: PDI_BYTE_W] = b; // [RL5]
      return d;
   endfunction : place

   function automatic logic [PDI_WORD_W-1:0] record(pdi_dq_entry_t e);
      logic [PDI_WORD_W-1:0] d;
      d = '0;
      // Outgoing records report the error as gone
      if (!e.outgoing) begin
         d[PDI_REC_MODULE_FAIL] = 1'b1;
         if (int'(e.source) < PDI_CH) begin
            d[PDI_REC_CHAN_INFO] = 1'b1;
            d[PDI_REC_LOST] = 1'b1; // [RL20]
         end else begin
            d[PDI_REC_INT_ERR] = 1'b1;
            if (int'(e.source) == PDI_CH + PDI_FLT_BUS_SUPPLY) begin
               d[PDI_REC_EXT_ERR] = 1'b1;
               d[PDI_REC_EXT_SUPPLY] = 1'b1;
            end
            if (int'(e.source) == PDI_CH + PDI_FLT_OUT_SUPPLY ||
                  int'(e.source) == PDI_CH + PDI_FLT_IN_SUPPLY) begin
               d[PDI_REC_INT_SUPPLY] = 1'b1;
            end
         end
      end
      return d;
   endfunction : record

   // Full queue drops the entry; depth covers two entries per source
   function automatic pdi_state_t dq_push(pdi_state_t s, logic o, logic [3:0] src);
      if ((s.dq_wr - s.dq_rd) != (DQW+1)'(DIAG_DEPTH)) begin
         s.dq[s.dq_wr[DQW-1:0]] = '{outgoing: o, source: src}; // [RL21]
         s.dq_wr = s.dq_wr + 1'b1;
      end
      return s;
   endfunction : dq_push

   // ==========================================================
   // Next state
   always_comb begin
      logic [PDI_ALARM_PINS-1:0] edges;
      logic [PDI_FAULTS-1:0] f_rise;
      logic [PDI_FAULTS-1:0] f_fall;
      logic [PDI_BYTE_W-1:0] ev;
      logic in_proc;
      logic [PDI_CHW-1:0] ch;
      pdi_dq_entry_t e;
      logic [31:0] rd;
      edges = '0;
      f_rise = '0;
      f_fall = '0;
      ev = '0;
      in_proc = 1'b0;
      ch = '0;
      e = '0;
      rd = '0;
      r_next = r_reg;
      r_next.log = 1'b0;

      // Pins cross two flops before the edge detector sees them
      r_next.pin_s1 = alarm_pins_in;
      r_next.pin_s2 = r_reg.pin_s1;
      r_next.pin_prev = r_reg.pin_s2;
      r_next.flt_s1 = fault_pins_in;
      r_next.flt_s2 = r_reg.flt_s1;
      r_next.flt_prev = r_reg.flt_s2;
      edges = r_reg.pin_s2 ^ r_reg.pin_prev;
      f_rise = r_reg.flt_s2 & ~r_reg.flt_prev;
      f_fall = ~r_reg.flt_s2 & r_reg.flt_prev;

      // Register writes
      if (bus_wr_in) begin
         case (bus_addr_in)
            PDI_CTRL_ADDR: begin
               r_next.mode = pdi_mode_t'(bus_wdata_in[PDI_CTRL_MODE_LSB +: 2]);
               r_next.irq_sel = bus_wdata_in[PDI_CTRL_IRQSEL_BIT];
               r_next.software_count_gate = bus_wdata_in[PDI_CTRL_SWGATE_BIT];
            end
            PDI_BASE_ADDR: r_next.base = bus_wdata_in[15:0];
            PDI_DIAG_REC_ADDR: r_next.diag_en = bus_wdata_in[PDI_DIAG_EN_BIT]; // [RL10]
            default: ;
         endcase
      end

      // Register reads, data in the following cycle only
      if (bus_rd_in) begin
         case (bus_addr_in)
            PDI_CTRL_ADDR: begin
               rd[PDI_CTRL_MODE_LSB +: 2] = r_reg.mode;
               rd[PDI_CTRL_IRQSEL_BIT] = r_reg.irq_sel;
               rd[PDI_CTRL_SWGATE_BIT] = r_reg.software_count_gate;
            end
            PDI_BASE_ADDR: rd[15:0] = r_reg.base;
            PDI_DIAG_REC_ADDR: rd[PDI_DIAG_EN_BIT] = r_reg.diag_en;
            PDI_STAT_ADDR: begin
               rd[PDI_STAT_ACTIVE_LSB +: PDI_SRCS] = r_reg.active;
               rd[PDI_STAT_LOST_LSB +: PDI_CH] = r_reg.lost;
               rd[PDI_STAT_DISP_LSB +: 2] = r_reg.disp;
               rd[PDI_STAT_SUSP_BIT] = r_reg.susp;
               rd[PDI_STAT_SFI_BIT] = r_reg.sfi;
               rd[PDI_STAT_PQ_LSB +: PDI_CHW+1] = r_reg.pq_wr - r_reg.pq_rd;
               rd[PDI_STAT_DQ_LSB +: DQW+1] = r_reg.dq_wr - r_reg.dq_rd;
            end
            default: rd = '0;
         endcase
      end
      r_next.rdata = rd;

      // Handler done with a diagnostic; clears go first so a set in this cycle wins
      if (r_reg.disp == D_DIAG && diag_ack_in) begin // [RL22]
         if (r_reg.diag_info.outgoing) begin
            r_next.active[r_reg.diag_info.source] = 1'b0; // [RL18]
            if (int'(r_reg.diag_info.source) < PDI_CH) begin
               r_next.lost[r_reg.diag_info.source[PDI_CHW-1:0]] = 1'b0; // [RL17]
            end
         end
         r_next.disp = r_reg.susp ? D_PROC : D_IDLE;
         r_next.susp = 1'b0;
      end

      // Channel events
      in_proc = (r_reg.disp == D_PROC) || r_reg.susp;
      for (int c = 0; c < PDI_CH; c++) begin
         ev = chan_bits(r_reg.mode, c, edges, cnt_events_in, freq_end_in, r_reg.software_count_gate);
         if (r_reg.irq_sel && ev != '0 && !r_reg.lost[c]) begin // [RL4] [RL15] [RL17]
            if (in_proc && r_reg.svc_ch == PDI_CHW'(c)) begin
               if (r_reg.diag_en) begin
                  r_next.lost[c] = 1'b1; // [RL11]
                  r_next.active[c] = 1'b1; // [RL18]
                  r_next = dq_push(r_next, 1'b0, 4'(c)); // [RL3] [RL11]
               end
            end else begin
               // Repeats of a queued channel merge into its held byte
               r_next.pend[c] = r_next.pend[c] | ev; // [RL13]
               if (!r_next.queued[c]) begin
                  r_next.queued[c] = 1'b1;
                  r_next.pq[r_next.pq_wr[PDI_CHW-1:0]] = PDI_CHW'(c); // [RL21]
                  r_next.pq_wr = r_next.pq_wr + 1'b1;
               end
            end
         end
      end

      // Supply and short circuit faults
      for (int i = 0; i < PDI_FAULTS; i++) begin
         if (f_rise[i] && r_reg.diag_en) begin
            r_next.active[PDI_CH+i] = 1'b1; // [RL18]
            r_next = dq_push(r_next, 1'b0, 4'(PDI_CH + i)); // [RL3]
         end
         if (f_fall[i] && r_reg.active[PDI_CH+i]) begin
            r_next = dq_push(r_next, 1'b1, 4'(PDI_CH + i));
         end
      end

      // Acknowledges
      if (r_reg.disp == D_PROC && proc_ack_in) begin // [RL22]
         r_next.disp = D_IDLE;
         if (r_next.lost[r_reg.svc_ch]) begin
            r_next = dq_push(r_next, 1'b1, 4'(r_reg.svc_ch)); // [RL16]
         end
      end

      // Dispatch: diagnostics before process interrupts
      if (r_next.disp != D_DIAG && r_next.dq_wr != r_next.dq_rd) begin // [RL14]
         e = r_next.dq[r_next.dq_rd[DQW-1:0]];
         r_next.dq_rd = r_next.dq_rd + 1'b1;
         r_next.susp = (r_next.disp == D_PROC); // [RL12]
         r_next.disp = D_DIAG;
         r_next.diag_info = '{outgoing: e.outgoing, source: e.source, record: record(e)};
         r_next.log = 1'b1; // [RL19]
      end else if (r_next.disp == D_IDLE && r_next.pq_wr != r_next.pq_rd) begin // [RL14]
         ch = r_next.pq[r_next.pq_rd[PDI_CHW-1:0]];
         r_next.pq_rd = r_next.pq_rd + 1'b1;
         r_next.proc_info.base_addr = r_reg.base; // [RL5]
         r_next.proc_info.detail = place(ch, r_next.pend[ch]); // [RL5]
         r_next.pend[ch] = '0;
         r_next.queued[ch] = 1'b0;
         r_next.svc_ch = ch;
         r_next.disp = D_PROC;
      end

      r_next.sfi = |r_next.active; // [RL18]
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Outputs
   // A preempted process service drops its request until the diagnostic is done
   assign proc_irq_out = (r_reg.disp == D_PROC); // [RL12]
   assign diag_irq_out = (r_reg.disp == D_DIAG);
   assign proc_info_out = r_reg.proc_info;
   assign diag_info_out = r_reg.diag_info;
   assign diag_log_out = r_reg.log;
   assign system_fault_indicator_out = r_reg.sfi;
   assign bus_rdata_out = r_reg.rdata;

endmodule : pdi_irq_unit

// ==== testbench/pdi_irq_unit_props.sv ====
// Port-level checks of the interrupt unit
`timescale 1ns/1ps
module pdi_irq_unit_props (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] bus_addr_in,
   input wire logic [31:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic [31:0] bus_rdata_out,
   input wire logic [pdi_pkg::PDI_ALARM_PINS-1:0] alarm_pins_in,
   input wire pdi_pkg::pdi_cnt_ev_t cnt_events_in,
   input wire logic [pdi_pkg::PDI_CH-1:0] freq_end_in,
   input wire logic [pdi_pkg::PDI_FAULTS-1:0] fault_pins_in,
   input wire logic proc_ack_in,
   input wire logic diag_ack_in,
   input wire logic proc_irq_out,
   input wire pdi_pkg::pdi_proc_info_t proc_info_out,
   input wire logic diag_irq_out,
   input wire pdi_pkg::pdi_diag_info_t diag_info_out,
   input wire logic diag_log_out,
   input wire logic system_fault_indicator_out
);
   import pdi_pkg::*;
   // ==========================================================
   // Sequences and properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_busy;
      proc_irq_out && !proc_ack_in;
   endsequence
   sequence s_preempt;
      proc_irq_out ##1 (diag_irq_out && !diag_info_out.outgoing);
   endsequence
   property p_rd_idle;
      !$past(bus_rd_in) |-> bus_rdata_out == 32'h0000_0000;
   endproperty
   property p_excl;
      !(proc_irq_out && diag_irq_out);
   endproperty
   property p_proc_stand;
      s_busy |=> proc_irq_out || diag_irq_out;
   endproperty
   property p_preempt;
      s_preempt |-> diag_log_out && !proc_irq_out;
   endproperty
   property p_log_rise;
      $rose(diag_irq_out) |-> diag_log_out;
   endproperty
   property p_log_in_diag;
      diag_log_out |-> diag_irq_out;
   endproperty
   // Log is a single pulse, so a held diagnostic must not log twice
   property p_diag_stand;
      diag_irq_out && !diag_ack_in |=> diag_irq_out && $stable(diag_info_out) && !diag_log_out;
   endproperty
   property p_sfi_in;
      diag_irq_out && !diag_info_out.outgoing |-> system_fault_indicator_out;
   endproperty
   property p_sfi_off;
      $fell(system_fault_indicator_out) |->
         $past(diag_ack_in && diag_irq_out && diag_info_out.outgoing);
   endproperty
   property p_out_zero;
      diag_irq_out && diag_info_out.outgoing |-> diag_info_out.record == 32'h0000_0000;
   endproperty
   property p_lost_bit;
      diag_irq_out && !diag_info_out.outgoing && diag_info_out.source < 4'h4 |->
         diag_info_out.record[PDI_REC_LOST];
   endproperty
   property p_detail;
      proc_irq_out |-> proc_info_out.detail != 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   a_excl: assert property (p_excl) else $error("both irqs high");
   a_proc_stand: assert property (p_proc_stand) else $error("proc irq dropped");
   a_preempt: assert property (p_preempt) else $error("no preemption");
   a_log_rise: assert property (p_log_rise) else $error("diag without log");
   a_log_in_diag: assert property (p_log_in_diag) else $error("stray log");
   a_diag_stand: assert property (p_diag_stand) else $error("diag not held");
   a_sfi_in: assert property (p_sfi_in) else $error("indicator dark");
   a_sfi_off: assert property (p_sfi_off) else $error("indicator off early");
   a_out_zero: assert property (p_out_zero) else $error("outgoing record");
   a_lost_bit: assert property (p_lost_bit) else $error("lost bit clear");
   a_detail: assert property (p_detail) else $error("empty detail");
endmodule : pdi_irq_unit_props

// ==== testbench/pdi_irq_unit_test.sv ====
// Directed bench for the interrupt unit
`timescale 1ns/1ps
module pdi_irq_unit_test;
   import pdi_pkg::*;
   // ==========================================================
   // Signals
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] bus_addr_in = 8'h00;
   logic [31:0] bus_wdata_in = 32'h0000_0000;
   logic bus_wr_in = 1'b0;
   logic bus_rd_in = 1'b0;
   logic [15:0] alarm_pins_in = 16'h0000;
   pdi_cnt_ev_t cnt_events_in = '0;
   logic [3:0] freq_end_in = 4'h0;
   logic [4:0] fault_pins_in = 5'h00;
   logic proc_ack_in = 1'b0;
   logic diag_ack_in = 1'b0;
   logic [31:0] bus_rdata_out;
   logic proc_irq_out, diag_irq_out, diag_log_out, system_fault_indicator_out;
   pdi_proc_info_t proc_info_out;
   pdi_diag_info_t diag_info_out;
   int bad_count = 0;
   int n_tests = 0;
   pdi_cnt_ev_t ev;
   int pins [4] = '{0, 7, 8, 15};
   always #5 clk_in = ~clk_in;
   pdi_irq_unit i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_addr_in(bus_addr_in),
      .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
      .bus_rdata_out(bus_rdata_out), .alarm_pins_in(alarm_pins_in),
      .cnt_events_in(cnt_events_in), .freq_end_in(freq_end_in), .fault_pins_in(fault_pins_in),
      .proc_ack_in(proc_ack_in), .diag_ack_in(diag_ack_in), .proc_irq_out(proc_irq_out),
      .proc_info_out(proc_info_out), .diag_irq_out(diag_irq_out),
      .diag_info_out(diag_info_out), .diag_log_out(diag_log_out),
      .system_fault_indicator_out(system_fault_indicator_out));
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus_addr_in <= a;
      bus_wdata_in <= d;
      bus_wr_in <= 1'b1;
      @(posedge clk_in);
      bus_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_in);
      bus_addr_in <= a;
      bus_rd_in <= 1'b1;
      @(posedge clk_in);
      bus_rd_in <= 1'b0;
      #1 chk(what, exp, bus_rdata_out);
   endtask : rd
   task automatic fire(input pdi_cnt_ev_t ce, input logic [3:0] fe);
      @(posedge clk_in);
      cnt_events_in <= ce;
      freq_end_in <= fe;
      @(posedge clk_in);
      cnt_events_in <= '0;
      freq_end_in <= 4'h0;
      #1;
   endtask : fire
   task automatic ack(input bit diag);
      @(posedge clk_in);
      if (diag) diag_ack_in <= 1'b1;
      else proc_ack_in <= 1'b1;
      @(posedge clk_in);
      diag_ack_in <= 1'b0;
      proc_ack_in <= 1'b0;
      #1;
   endtask : ack
   // Bounded wait, also used to prove that nothing arrives
   task automatic wait_irq(input bit diag);
      for (int i = 0; i < 12; i++) begin
         if ((diag ? diag_irq_out : proc_irq_out) === 1'b1) break;
         @(posedge clk_in);
         #1;
      end
   endtask : wait_irq
   task automatic chk_proc(input logic [31:0] exp);
      chk("proc irq", 32'h0000_0001, 32'(proc_irq_out));
      chk("detail", exp, proc_info_out.detail);
      chk("base", 32'h0000_1234, 32'(proc_info_out.base_addr));
      ack(1'b0);
   endtask : chk_proc
   task automatic chk_diag(input logic [3:0] src, input logic outg, input logic lg = 1'b1);
      chk("diag irq", 32'h0000_0001, 32'(diag_irq_out));
      chk("log", 32'(lg), 32'(diag_log_out));
      chk("source", 32'(src), 32'(diag_info_out.source));
      chk("outgoing", 32'(outg), 32'(diag_info_out.outgoing));
      chk("indicator", 32'h0000_0001, 32'(system_fault_indicator_out));
      ack(1'b1);
   endtask : chk_diag
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // ==========================================================
   // Tests
   initial begin
      repeat (5000) @(posedge clk_in);
      bad_count++;
      stop_test;
   end
   initial begin
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rd(PDI_STAT_ADDR, 32'h0000_0000, "status");
      rd(PDI_CTRL_ADDR, 32'h0000_0000, "ctrl");
      wr(PDI_BASE_ADDR, 32'h0000_1234);
      rd(PDI_BASE_ADDR, 32'h0000_1234, "base reg");
      rd(8'hF0, 32'h0000_0000, "unmapped");
      wr(PDI_CTRL_ADDR, 32'h0000_0001);
      ev = '0;
      ev.cmp[1] = 1'b1;
      fire(ev, 4'h0);
      chk("selection off", 32'h0000_0000, 32'(proc_irq_out));
      $display("test registers done");
      wr(PDI_CTRL_ADDR, 32'h0000_0005);
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 2; k++) begin
            ev = '0;
            if (k == 1) ev.wrap[c] = 1'b1;
            else ev.cmp[c] = 1'b1;
            fire(ev, 4'h0);
            chk_proc((k == 1 ? 32'h0000_0004 : 32'h0000_0008) << (8 * (3 - c)));
         end
      end
      fire(11'h004, 4'h0);
      chk("gate with software_count_gate shut", 32'h0000_0000, 32'(proc_irq_out));
      wr(PDI_CTRL_ADDR, 32'h0000_000D);
      for (int g = 0; g < 3; g++) begin
         fire(11'h004 >> g, 4'h0);
         chk_proc(g == 2 ? 32'h0000_0010 : 32'h0000_0001 << g);
      end
      wr(PDI_CTRL_ADDR, 32'h0000_0006);
      for (int c = 0; c < 4; c++) begin
         fire('0, 4'(1 << c));
         chk_proc(32'h0000_0001 << (8 * (3 - c)));
      end
      wr(PDI_CTRL_ADDR, 32'h0000_0004);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         alarm_pins_in <= alarm_pins_in ^ (16'h0001 << pins[i / 2]);
         #1 wait_irq(1'b0);
         chk_proc(32'h0000_0001 << (pins[i / 2] < 8 ? 24 + pins[i / 2] : 8 + pins[i / 2]));
      end
      $display("test events done");
      // Lost event escalates; other channel held, own channel dropped
      wr(PDI_DIAG_REC_ADDR, 32'h0000_0001);
      wr(PDI_CTRL_ADDR, 32'h0000_0005);
      ev = '0;
      ev.cmp[0] = 1'b1;
      fire(ev, 4'h0);
      fire(ev, 4'h0);
      chk("log at preempt", 32'h0000_0001, 32'(diag_log_out));
      chk("preempted", 32'h0000_0000, 32'(proc_irq_out));
      chk("lost bit", 32'h0000_0001, 32'(diag_info_out.record[PDI_REC_LOST]));
      fire(11'h010, 4'h0);
      fire(ev, 4'h0);
      chk("held", 32'h0000_0000, 32'(proc_irq_out));
      chk_diag(4'h0, 1'b0, 1'b0);
      chk_proc(32'h0800_0000);
      wait_irq(1'b1);
      chk_diag(4'h0, 1'b1);
      chk("indicator off", 32'h0000_0000, 32'(system_fault_indicator_out));
      wait_irq(1'b0);
      chk_proc(32'h0008_0000);
      wait_irq(1'b0);
      chk("dropped", 32'h0000_0000, 32'(proc_irq_out));
      $display("test lost done");
      wr(PDI_DIAG_REC_ADDR, 32'h0000_0000);
      @(posedge clk_in);
      fault_pins_in <= 5'h01;
      #1 wait_irq(1'b1);
      chk("diag disabled", 32'h0000_0000, 32'(diag_irq_out));
      @(posedge clk_in);
      fault_pins_in <= 5'h00;
      wr(PDI_DIAG_REC_ADDR, 32'h0000_0001);
      for (int k = 0; k < 5; k++) begin
         @(posedge clk_in);
         fault_pins_in <= 5'(1 << k);
         #1 wait_irq(1'b1);
         chk_diag(4'(k + 4), 1'b0);
         @(posedge clk_in);
         fault_pins_in <= 5'h00;
         #1 wait_irq(1'b1);
         chk_diag(4'(k + 4), 1'b1);
         chk("indicator", 32'h0000_0000, 32'(system_fault_indicator_out));
      end
      $display("test faults done");
      stop_test;
   end
endmodule : pdi_irq_unit_test

bind pdi_irq_unit pdi_irq_unit_props i_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
   .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .alarm_pins_in(alarm_pins_in),
   .cnt_events_in(cnt_events_in), .freq_end_in(freq_end_in), .fault_pins_in(fault_pins_in),
   .proc_ack_in(proc_ack_in), .diag_ack_in(diag_ack_in), .proc_irq_out(proc_irq_out),
   .proc_info_out(proc_info_out), .diag_irq_out(diag_irq_out),
   .diag_info_out(diag_info_out), .diag_log_out(diag_log_out),
   .system_fault_indicator_out(system_fault_indicator_out));
